// File: rtl/tws_master_tx.sv
// Two-wire master transmitter with register port and open-drain bus pins
//
// Chosen here: the strobed register port and the address map.
`default_nettype none
module tws_master_tx (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [tws_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic irq
);
    tws_pkg::tws_ctrl_t ctl_q, ctl_d, wctl;
    tws_pkg::tws_state_t st_q, st_d;
    logic [7:0] code_q, code_d, data_q, sh_q, sh_d, rdata_q, rdata_d;
    logic [7:0] rate_q;
    logic [1:0] ps_q;
    logic [3:0] role_q;
    logic [2:0] bit_q, bit_d;
    logic [15:0] cnt_q, cnt_d;
    logic lost_q, lost_d, addr_ph_q, addr_ph_d, mrx_q, mrx_d, rs_q, rs_d;
    logic busy_q, sda_p_q, scl_oe_q, sda_oe_q, irq_q, low_q;
    logic scl_s, sda_s;

    // =========================================================================
    // Pin synchronisers
    // =========================================================================
    tws_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .d({scl_in, sda_in}),
        .q({scl_s, sda_s})
    );

    // =========================================================================
    // Register decode
    // =========================================================================
    wire wr_ctrl = reg_wr && (reg_addr == tws_pkg::REG_CTRL);
    wire wr_data = reg_wr && (reg_addr == tws_pkg::REG_DATA);
    wire wr_stat = reg_wr && (reg_addr == tws_pkg::REG_STAT);
    wire wr_rate = reg_wr && (reg_addr == tws_pkg::REG_RATE);
    wire wr_role = reg_wr && (reg_addr == tws_pkg::REG_ROLE);
    assign wctl = tws_pkg::tws_ctrl_t'(reg_wdata);
    // A flag write only counts when enable stays set in the same write
    wire clr = wr_ctrl && wctl.flag && wctl.en;
    // Enable as it stands after this edge, so a start written with enable is not lost
    wire en_now = wr_ctrl ? wctl.en : ctl_q.en;
    wire go = clr && ctl_q.flag && (st_q == tws_pkg::TS_HOLD);
    wire master_ok = role_q[tws_pkg::ROLE_MT] || role_q[tws_pkg::ROLE_MR];
    wire dir_ok = data_q[0] ? role_q[tws_pkg::ROLE_MR] : role_q[tws_pkg::ROLE_MT];
    wire start_req = clr && wctl.sta && !wctl.sto && master_ok
                     && (st_q == tws_pkg::TS_IDLE);

    // =========================================================================
    // Bit timing: half period is (rate+1) times 4 to the prescaler power
    // =========================================================================
    wire [15:0] rate_ext = {8'h00, rate_q} + 16'h0001;
    wire [15:0] half_w = rate_ext << {ps_q, 1'b0};
    wire hi_st = (st_q == tws_pkg::TS_START_HI) || (st_q == tws_pkg::TS_BIT_HI)
                 || (st_q == tws_pkg::TS_ACK_HI) || (st_q == tws_pkg::TS_STOP_HI)
                 || (st_q == tws_pkg::TS_RS_HI);
    // High phases wait for the wire itself so a slave may stretch the clock
    wire done = (cnt_q == 16'h0000) && (!hi_st || scl_s);
    wire ack_w = !sda_s;
    wire lose = sh_q[7] && !sda_s; // Sent high but read low: another master won

    // =========================================================================
    // Sequencer
    // =========================================================================
    logic ev_set, stop_done;
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        lost_d = lost_q;
        addr_ph_d = addr_ph_q;
        mrx_d = mrx_q;
        rs_d = rs_q;
        ev_set = 1'b0;
        code_d = code_q;
        stop_done = 1'b0;
        case (st_q)
            tws_pkg::TS_IDLE: begin
                if (start_req) begin
                    st_d = tws_pkg::TS_WAIT_FREE;
                    rs_d = 1'b0;
                end
            end
            tws_pkg::TS_WAIT_FREE: if (!busy_q) st_d = tws_pkg::TS_START_HI;
            tws_pkg::TS_START_HI: if (done) st_d = tws_pkg::TS_START_LO;
            tws_pkg::TS_START_LO: begin
                if (done) begin
                    st_d = tws_pkg::TS_HOLD;
                    ev_set = 1'b1;
                    code_d = rs_q ? tws_pkg::CODE_RSTART : tws_pkg::CODE_START;
                    addr_ph_d = 1'b1;
                    mrx_d = 1'b0;
                    lost_d = 1'b0;
                end
            end
            tws_pkg::TS_HOLD: begin
                if (go) begin
                    if (lost_q) begin
                        st_d = wctl.sta ? tws_pkg::TS_WAIT_FREE : tws_pkg::TS_IDLE;
                        rs_d = 1'b0;
                    end else if (wctl.sto) begin
                        st_d = tws_pkg::TS_STOP_LO;
                    end else if (wctl.sta) begin
                        st_d = tws_pkg::TS_RS_LO;
                        rs_d = 1'b1;
                    end else if (mrx_q || (addr_ph_q && !dir_ok)) begin
                        st_d = tws_pkg::TS_STOP_LO;
                    end else begin
                        st_d = tws_pkg::TS_BIT_LO;
                        sh_d = data_q;
                        bit_d = tws_pkg::BIT_LAST;
                    end
                end
            end
            tws_pkg::TS_BIT_LO: if (done) st_d = tws_pkg::TS_BIT_HI;
            tws_pkg::TS_BIT_HI: begin
                if (done) begin
                    if (lose) begin
                        st_d = tws_pkg::TS_HOLD;
                        ev_set = 1'b1;
                        code_d = tws_pkg::CODE_ARB_LOST;
                        lost_d = 1'b1;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b0};
                        bit_d = bit_q - 3'h1;
                        st_d = (bit_q == 3'h0) ? tws_pkg::TS_ACK_LO : tws_pkg::TS_BIT_LO;
                    end
                end
            end
            tws_pkg::TS_ACK_LO: if (done) st_d = tws_pkg::TS_ACK_HI;
            tws_pkg::TS_ACK_HI: begin
                if (done) begin
                    st_d = tws_pkg::TS_HOLD;
                    ev_set = 1'b1;
                    addr_ph_d = 1'b0;
                    if (addr_ph_q && data_q[0]) begin
                        mrx_d = 1'b1;
                        code_d = ack_w ? tws_pkg::CODE_AR_ACK : tws_pkg::CODE_AR_NACK;
                    end else if (addr_ph_q) begin
                        code_d = ack_w ? tws_pkg::CODE_AW_ACK : tws_pkg::CODE_AW_NACK;
                    end else begin
                        code_d = ack_w ? tws_pkg::CODE_D_ACK : tws_pkg::CODE_D_NACK;
                    end
                end
            end
            tws_pkg::TS_STOP_LO: if (done) st_d = tws_pkg::TS_STOP_HI;
            tws_pkg::TS_STOP_HI: if (done) st_d = tws_pkg::TS_STOP_END;
            tws_pkg::TS_STOP_END: begin
                if (done) begin
                    stop_done = 1'b1;
                    rs_d = 1'b0;
                    st_d = ctl_q.sta ? tws_pkg::TS_WAIT_FREE : tws_pkg::TS_IDLE;
                end
            end
            tws_pkg::TS_RS_LO: if (done) st_d = tws_pkg::TS_RS_HI;
            tws_pkg::TS_RS_HI: if (done) st_d = tws_pkg::TS_START_HI;
            default: st_d = tws_pkg::TS_IDLE;
        endcase
        if (!en_now) begin
            st_d = tws_pkg::TS_IDLE;
            ev_set = 1'b0;
        end
    end

    // Counter restarts on every state change
    assign cnt_d = (st_d != st_q) ? half_w
                 : ((cnt_q != 16'h0000) && !(hi_st && !scl_s)) ? cnt_q - 16'h0001 : cnt_q;

    // =========================================================================
    // Pin drive: clock decoded from the next state, data from the current state, both pins from flops
    // =========================================================================
    wire scl_low_d = ((st_d == tws_pkg::TS_HOLD) && !lost_d)
                     || (st_d == tws_pkg::TS_START_LO) || (st_d == tws_pkg::TS_BIT_LO)
                     || (st_d == tws_pkg::TS_ACK_LO) || (st_d == tws_pkg::TS_STOP_LO)
                     || (st_d == tws_pkg::TS_RS_LO);
    // Data follows the current state, a cycle behind the clock, so it never moves
    // together with a clock edge on the wire and fakes a START or STOP
    wire bit_st = (st_q == tws_pkg::TS_BIT_LO) || (st_q == tws_pkg::TS_BIT_HI);
    wire sda_low_d = (bit_st && !sh_q[7])
                     || (st_q == tws_pkg::TS_START_HI) || (st_q == tws_pkg::TS_START_LO)
                     || (st_q == tws_pkg::TS_STOP_LO) || (st_q == tws_pkg::TS_STOP_HI);

    // =========================================================================
    // Control register next value; a hardware set wins over a clear
    // =========================================================================
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctrl) begin
            ctl_d.ack_enable = wctl.ack_enable;
            ctl_d.sta = wctl.sta;
            ctl_d.sto = wctl.sto;
            ctl_d.en = wctl.en;
            ctl_d.event_irq_enable = wctl.event_irq_enable;
        end
        if (stop_done && !wr_ctrl) ctl_d.sto = 1'b0;
        ctl_d.flag = ev_set || (ctl_q.flag && !clr && ctl_q.en);
        if (wr_data) ctl_d.write_collision = !ctl_q.flag;
        ctl_d.rsv = 1'b0;
    end

    wire [7:0] rd_sel = (reg_addr == tws_pkg::REG_CTRL) ? ctl_q
                      : (reg_addr == tws_pkg::REG_STAT) ? {code_q[7:3], 1'b0, ps_q}
                      : (reg_addr == tws_pkg::REG_DATA) ? data_q
                      : (reg_addr == tws_pkg::REG_RATE) ? rate_q
                      : (reg_addr == tws_pkg::REG_ROLE) ? {busy_q, mrx_q, lost_q, 1'b0, role_q}
                      : 8'h00;
    assign rdata_d = reg_rd ? rd_sel : 8'h00;

    // =========================================================================
    // Register and state flops
    // =========================================================================
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctl_q <= tws_pkg::CTRL_RST;
            st_q <= tws_pkg::TS_IDLE;
            code_q <= tws_pkg::CODE_NONE;
            data_q <= tws_pkg::DATA_RST;
            rate_q <= tws_pkg::RATE_RST;
            ps_q <= tws_pkg::PS_RST;
            role_q <= tws_pkg::ROLE_RST;
            rdata_q <= 8'h00;
        end else begin
            ctl_q <= ctl_d;
            st_q <= st_d;
            code_q <= code_d;
            if (wr_data && ctl_q.flag) data_q <= reg_wdata;
            if (wr_rate) rate_q <= reg_wdata;
            if (wr_stat) ps_q <= reg_wdata[1:0];
            if (wr_role) role_q <= reg_wdata[3:0];
            rdata_q <= rdata_d;
        end
    end

    // Shifter, counters and bus observers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            cnt_q <= 16'h0000;
            lost_q <= 1'b0;
            addr_ph_q <= 1'b0;
            mrx_q <= 1'b0;
            rs_q <= 1'b0;
            busy_q <= 1'b0;
            sda_p_q <= 1'b1;
        end else begin
            sh_q <= sh_d;
            bit_q <= bit_d;
            cnt_q <= cnt_d;
            lost_q <= lost_d;
            addr_ph_q <= addr_ph_d;
            mrx_q <= mrx_d;
            rs_q <= rs_d;
            sda_p_q <= sda_s;
            // START seen sets busy, STOP seen clears it
            if (scl_s && sda_p_q && !sda_s) busy_q <= 1'b1;
            else if (scl_s && !sda_p_q && sda_s) busy_q <= 1'b0;
        end
    end

    // Output flops
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            irq_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            scl_oe_q <= scl_low_d;
            sda_oe_q <= sda_low_d;
            irq_q <= ctl_d.flag && ctl_d.event_irq_enable;
            low_q <= 1'b0;
        end
    end

    assign reg_rdata = rdata_q;
    assign scl_out = low_q;
    assign sda_out = low_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign irq = irq_q;

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_release;
        reg_wr && (reg_addr == tws_pkg::REG_CTRL) && reg_wdata[7] && reg_wdata[2];
    endsequence
    sequence s_start_done;
        (st_q == tws_pkg::TS_START_LO) && done && en_now;
    endsequence

    a_start_code: assert property (s_start_done |=> ctl_q.flag
        && (code_q == (rs_q ? tws_pkg::CODE_RSTART : tws_pkg::CODE_START)))
        else $error("start completion did not raise flag with start code");
    a_hold_suspend: assert property (ctl_q.flag && (st_q == tws_pkg::TS_HOLD)
        && !reg_wr ##1 !reg_wr |-> $stable(st_q) && ctl_q.flag)
        else $error("transfer moved while event flag was set");
    a_hold_clock: assert property ((st_q == tws_pkg::TS_HOLD) && !lost_q
        |-> scl_oe)
        else $error("clock line not held low while flag set");
    a_flag_clear: assert property (s_release and (ctl_q.flag && !ev_set)
        |=> !ctl_q.flag)
        else $error("writing one to flag did not clear it");
    a_collision_set: assert property (reg_wr && (reg_addr == tws_pkg::REG_DATA)
        && !ctl_q.flag |=> ctl_q.write_collision && $stable(data_q))
        else $error("data write with flag low was not refused");
    a_addr_codes: assert property ((st_q == tws_pkg::TS_ACK_HI) && done
        && addr_ph_q && !data_q[0] && ctl_q.en
        |=> (code_q == tws_pkg::CODE_AW_ACK) || (code_q == tws_pkg::CODE_AW_NACK))
        else $error("address phase ended with wrong code");
    a_enable_off: assert property (!en_now |=> (st_q == tws_pkg::TS_IDLE)
        ##1 !scl_oe && !sda_oe)
        else $error("disabled interface still active");
    a_start_wait: assert property (start_req |=> (st_q == tws_pkg::TS_WAIT_FREE))
        else $error("start request not taken");
    a_irq_follow: assert property (ctl_q.flag && ctl_q.event_irq_enable
        |-> irq)
        else $error("interrupt missing while flag and enable set");
    a_repeat_start: assert property (go && !lost_q && wctl.sta && !wctl.sto
        |=> (st_q == tws_pkg::TS_RS_LO) && rs_q)
        else $error("repeated start not begun");
    a_lost_code: assert property ((st_q == tws_pkg::TS_BIT_HI) && done && lose
        && ctl_q.en |=> lost_q && (code_q == tws_pkg::CODE_ARB_LOST) ##1 !scl_oe)
        else $error("arbitration loss not reported or bus kept");
endmodule : tws_master_tx
`default_nettype wire

// File: rtl/tws_pkg.sv
// Shared constants, register layout and state types of the two-wire master transmitter
`default_nettype none
package tws_pkg;
    // =========================================================================
    // Register map
    // =========================================================================
    localparam int ADDR_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_RATE = 3'h3;
    localparam logic [2:0] REG_ROLE = 3'h4;

    // =========================================================================
    // Field positions and reset values
    // =========================================================================
    localparam int ROLE_MT = 0;
    localparam int ROLE_MR = 1;
    localparam int ROLE_ST = 2;
    localparam int ROLE_SR = 3;
    localparam int CODE_LSB = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h10;
    localparam logic [1:0] PS_RST = 2'h0;
    localparam logic [3:0] ROLE_RST = 4'hF;
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // =========================================================================
    // Status codes, prescaler bits taken as zero
    // =========================================================================
    localparam logic [7:0] CODE_NONE = 8'hF8;
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_AW_ACK = 8'h18;
    localparam logic [7:0] CODE_AW_NACK = 8'h20;
    localparam logic [7:0] CODE_D_ACK = 8'h28;
    localparam logic [7:0] CODE_D_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST = 8'h38;
    localparam logic [7:0] CODE_AR_ACK = 8'h40;
    localparam logic [7:0] CODE_AR_NACK = 8'h48;

    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic flag;
        logic ack_enable;
        logic sta;
        logic sto;
        logic write_collision;
        logic en;
        logic rsv;
        logic event_irq_enable;
    } tws_ctrl_t;

    typedef enum logic [3:0] {
        TS_IDLE, TS_WAIT_FREE, TS_START_HI, TS_START_LO, TS_HOLD,
        TS_BIT_LO, TS_BIT_HI, TS_ACK_LO, TS_ACK_HI,
        TS_STOP_LO, TS_STOP_HI, TS_STOP_END, TS_RS_LO, TS_RS_HI
    } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

// File: rtl/tws_sync.sv
// Two-flop synchroniser for asynchronous bus pins
`default_nettype none
module tws_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // =========================================================================
    // Synchroniser chain; the first stage feeds only the second
    // =========================================================================
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : tws_sync
`default_nettype wire

// File: sim/tws_slave_model.sv
// Behavioural slave receiver on the open-drain two-wire bus
`default_nettype none
module tws_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    input wire logic stretch,
    input wire logic steal,
    output logic sda_pull,
    output logic scl_pull,
    output logic [7:0] last_byte,
    output int stops
);
    timeunit 1ns;
    timeprecision 1ps;
    logic active;
    logic [7:0] shift;
    int bits;
    // =========================================================================
    // Idle: both wires released to the pull-up
    initial begin
        active = 1'b0;
        bits = 0;
        stops = 0;
        shift = 8'h00;
        last_byte = 8'h00;
        sda_pull = 1'b0;
        scl_pull = 1'b0;
    end
    // START or repeated START: data falls while clock is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            bits = 0;
        end
    end
    // STOP: data rises while clock is high, bus free again
    always @(posedge sda) begin
        if (scl === 1'b1 && active) begin
            active = 1'b0;
            stops++;
        end
    end
    // Bits are taken while the clock is high, first bit is the MSB
    always @(posedge scl) begin
        if (active && bits < 8) begin
            shift = {shift[6:0], sda};
            bits++;
        end
    end
    // Answer slot, then an optional stretch; steal imitates a rival master
    always @(negedge scl) begin
        if (active) begin
            if (bits == 8) begin
                last_byte = shift;
                sda_pull = ~nack;
                bits = 9;
            end else if (bits == 9) begin
                sda_pull = 1'b0;
                bits = 0;
                if (stretch) begin
                    scl_pull = 1'b1;
                    #200 scl_pull = 1'b0;
                end
            end else begin
                sda_pull = steal;
            end
        end
    end
endmodule : tws_slave_model
`default_nettype wire

// File: sim/tws_master_tx_tb_top.sv
// Bench: register-port sessions against a model slave receiver
`default_nettype none
module tws_master_tx_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, reg_wr, reg_rd, scl_oe, sda_oe, scl_out, sda_out, irq;
    logic nack, stretch, steal, s_sda, s_scl;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v, got;
    int failures, checks, stops, n0;
    wire scl_w;
    wire sda_w;
    // =========================================================================
    // Open-drain wires with pull-ups: low while any party pulls
    assign scl_w = ~(scl_oe | s_scl);
    assign sda_w = ~(sda_oe | s_sda);
    tws_master_tx uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    tws_slave_model slv (.scl(scl_w), .sda(sda_w), .nack(nack), .stretch(stretch),
        .steal(steal), .sda_pull(s_sda), .scl_pull(s_scl), .last_byte(got), .stops(stops));
    // Clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // =========================================================================
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle strobes, changed just after the edge
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rd
    task rchk(input logic [2:0] a, input logic [7:0] e);
        rd(a, v);
        chk(v, e);
    endtask : rchk
    // Polling is bounded so a lost event cannot hang the run
    task wait_flag(input logic [7:0] code);
        v = 8'h00;
        for (int i = 0; i < 3000 && v[7] !== 1'b1; i++) begin
            rd(tws_pkg::REG_CTRL, v);
        end
        chk(v & 8'h80, 8'h80);
        rd(tws_pkg::REG_STAT, v);
        chk(v & 8'hF8, code);
    endtask : wait_flag
    task release_byte(input logic [7:0] d, input logic [7:0] code);
        wr(tws_pkg::REG_DATA, d);
        wr(tws_pkg::REG_CTRL, 8'h84);
        wait_flag(code);
    endtask : release_byte
    task conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // =========================================================================
    // Watchdog, well beyond the expected run length
    initial begin
        #600000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
    // Main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, rstn, nack, stretch, steal} = '0;
        failures = 0;
        checks = 0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        rchk(tws_pkg::REG_CTRL, tws_pkg::CTRL_RST);
        rchk(tws_pkg::REG_STAT, tws_pkg::CODE_NONE);
        rchk(tws_pkg::REG_DATA, tws_pkg::DATA_RST);
        rchk(tws_pkg::REG_RATE, tws_pkg::RATE_RST);
        rchk(tws_pkg::REG_ROLE, {4'h0, tws_pkg::ROLE_RST});
        wr(3'h5, 8'h55);
        rchk(3'h5, 8'h00);
        wr(tws_pkg::REG_DATA, 8'h12);
        rchk(tws_pkg::REG_CTRL, 8'h08);
        rchk(tws_pkg::REG_DATA, tws_pkg::DATA_RST);
        $display("test reset and collision done");
        wr(tws_pkg::REG_RATE, 8'h03);
        wr(tws_pkg::REG_ROLE, 8'h0C);
        wr(tws_pkg::REG_CTRL, 8'hA4);
        repeat (200) @(posedge core_clk);
        rd(tws_pkg::REG_CTRL, v);
        chk(v & 8'h80, 8'h00);
        wr(tws_pkg::REG_CTRL, 8'h00);
        wr(tws_pkg::REG_ROLE, 8'h0F);
        wr(tws_pkg::REG_CTRL, 8'hA0);
        repeat (200) @(posedge core_clk);
        rd(tws_pkg::REG_CTRL, v);
        chk({v[7], 6'h00, scl_oe}, 8'h00);
        $display("test role and enable done");
        wr(tws_pkg::REG_CTRL, 8'hA4);
        wait_flag(tws_pkg::CODE_START);
        repeat (20) @(posedge core_clk);
        chk({7'h00, scl_oe}, 8'h01);
        wr(tws_pkg::REG_DATA, 8'hA0);
        rchk(tws_pkg::REG_CTRL, 8'hA4);
        wr(tws_pkg::REG_CTRL, 8'h25);
        rchk(tws_pkg::REG_CTRL, 8'hA5);
        chk({7'h00, irq}, 8'h01);
        wr(tws_pkg::REG_CTRL, 8'h24);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irq}, 8'h00);
        wr(tws_pkg::REG_CTRL, 8'h84);
        wait_flag(tws_pkg::CODE_AW_ACK);
        chk(got, 8'hA0);
        release_byte(8'h5A, tws_pkg::CODE_D_ACK);
        chk(got, 8'h5A);
        nack = 1'b1;
        stretch = 1'b1;
        release_byte(8'h3C, tws_pkg::CODE_D_NACK);
        nack = 1'b0;
        stretch = 1'b0;
        $display("test write session done");
        wr(tws_pkg::REG_CTRL, 8'hA4);
        wait_flag(tws_pkg::CODE_RSTART);
        release_byte(8'hA1, tws_pkg::CODE_AR_ACK);
        rd(tws_pkg::REG_ROLE, v);
        chk(v & 8'h40, 8'h40);
        n0 = stops;
        wr(tws_pkg::REG_CTRL, 8'h94);
        for (int i = 0; i < 2000 && stops == n0; i++) @(posedge core_clk);
        repeat (10) @(posedge core_clk);
        chk(8'(stops - n0), 8'h01);
        rd(tws_pkg::REG_CTRL, v);
        chk({v[7], v[4], 2'h0, scl_out, sda_out, scl_oe, sda_oe}, 8'h00);
        $display("test repeated start and stop done");
        wr(tws_pkg::REG_CTRL, 8'hA4);
        wait_flag(tws_pkg::CODE_START);
        nack = 1'b1;
        release_byte(8'hA0, tws_pkg::CODE_AW_NACK);
        nack = 1'b0;
        wr(tws_pkg::REG_CTRL, 8'hA4);
        wait_flag(tws_pkg::CODE_RSTART);
        steal = 1'b1;
        release_byte(8'hA0, tws_pkg::CODE_ARB_LOST);
        wr(tws_pkg::REG_CTRL, 8'h84);
        repeat (20) @(posedge core_clk);
        rd(tws_pkg::REG_ROLE, v);
        chk({v[5], 5'h00, scl_oe, sda_oe}, 8'h80);
        steal = 1'b0;
        $display("test address refusal and arbitration done");
        conclude();
    end
endmodule : tws_master_tx_tb_top
`default_nettype wire
